// file: rtl/tbdo_defs.vh
// offsets, field positions, reset values and divider taps of the time base block
`ifndef TBDO_DEFS_VH
`define TBDO_DEFS_VH

`define TBDO_ADDR_W 8
`define TBDO_ADDR_CTRL 8'h36
`define TBDO_ADDR_STATUS 8'h37
`define TBDO_ADDR_MASK 8'h38

`define TBDO_CTRL_RESET 8'h00
`define TBDO_STATUS_RESET 4'h0
`define TBDO_MASK_RESET 4'h0

`define TBDO_BIT_SQ_EN 7
`define TBDO_BIT_SQ_RATE_HI 6
`define TBDO_BIT_SQ_RATE_LO 5
`define TBDO_BIT_LS_SRC 4
`define TBDO_BIT_TB_EN 3
`define TBDO_BIT_TB_RATE_HI 2
`define TBDO_BIT_TB_RATE_LO 0

`define TBDO_ST_TICK 0
`define TBDO_ST_RATE_MISUSE 1
`define TBDO_ST_SLOW_CODE 2
`define TBDO_ST_SQ_MISUSE 3
`define TBDO_ST_W 4

`define TBDO_CHAIN_W 23
`define TBDO_LOW_W 8
`define TBDO_LOW_WRAP 8'hff

// chain bit k-1 toggles at fc/2^k; fs enters above the low 8 stages
`define TBDO_TB_TAP0 5'd22
`define TBDO_TB_TAP1 5'd20
`define TBDO_TB_TAP2 5'd15
`define TBDO_TB_TAP3 5'd13
`define TBDO_TB_TAP4 5'd12
`define TBDO_TB_TAP5 5'd11
`define TBDO_TB_TAP6 5'd10
`define TBDO_TB_TAP7 5'd8
`define TBDO_SQ_TAP0 5'd12
`define TBDO_SQ_TAP1 5'd11
`define TBDO_SQ_TAP2 5'd10
`define TBDO_SQ_TAP3 5'd9

`define TBDO_SLOW_MAX_CODE 3'b001

`endif

// file: rtl/tbdo_divider.v
// shared free-running divider chain, fed by fc or by fs ticks
`timescale 1ns/1ps
`include "tbdo_defs.vh"

module tbdo_divider (
  input wire clk,
  input wire rst,
  input wire lowSpeed,
  input wire fsTick,
  output wire [`TBDO_CHAIN_W-1:0] chain
);

  reg [`TBDO_LOW_W-1:0] lowStages;
  reg [`TBDO_CHAIN_W-`TBDO_LOW_W-1:0] highStages;
  wire highStep;

  // in low-speed use the fs clock bypasses the low stages, so tap positions stay the same
  assign highStep = lowSpeed ? fsTick : (lowStages == `TBDO_LOW_WRAP);

  always @(posedge clk)
  begin
    if (rst)
    begin
      lowStages <= {`TBDO_LOW_W{1'b0}};
      highStages <= {(`TBDO_CHAIN_W-`TBDO_LOW_W){1'b0}};
    end
    else
    begin
      lowStages <= lowStages + 8'h01;
      if (highStep)
        highStages <= highStages + 15'h0001;
    end
  end

  assign chain = {highStages, lowStages};

endmodule // tbdo_divider

// file: rtl/tbdo_core.v
// time base timer and divider square-wave output with register port
// Operation
// - fc source: rate codes 000..111 pick fc/2^23,21,16,14,13,12,11,9.
// - low-speed source: rate codes pick fs/2^15,13,8,6,5,4,3,1.
// - interrupt on every falling edge of selected tap once enabled.
// - enabling never clears the divider; first interrupt may come early.
// - enable is control bit 3; rate field is bits 2 to 0.
// - bit 7 enables a roughly 50% duty square wave at selected rate.
// - fc source: square codes 00..11 pick fc/2^13,12,11,10 via bits 6:5.
// - low-speed source or slow modes: square codes pick fs/2^5,4,3,2.
// - square wave leaves on a dedicated active-low pin.
// - control register at 0x36, resets to zero, everything disabled.
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`include "tbdo_defs.vh"

module tbdo_core (
  input wire clk,
  input wire rst,
  input wire [`TBDO_ADDR_W-1:0] regAddr,
  input wire [7:0] regWriteData,
  input wire regWrite,
  input wire regRead,
  output reg [7:0] regReadData,
  input wire lowSpeedModes,
  input wire fsClockPin,
  output reg timeBaseInterrupt,
  output wire irq,
  output reg buzzerSquareOut_n
);

  reg [7:0] timeBaseControl;
  reg [`TBDO_ST_W-1:0] status;
  reg [`TBDO_ST_W-1:0] mask;
  reg fsSync1;
  reg fsSync2;
  reg fsPrev;
  reg tbTapPrev;
  reg [4:0] tbTapIndex;
  reg [4:0] sqTapIndex;
  reg [7:0] next_readData;
  reg [`TBDO_ST_W-1:0] next_status;
  wire [`TBDO_CHAIN_W-1:0] chain;
  wire fsTick;
  wire useLowSpeed;
  wire timeBaseEnable;
  wire [2:0] timeBaseRateSelect;
  wire squareOutEnable;
  wire [1:0] squareOutRateSelect;
  wire lowSpeedDividerSource;
  wire tbTap;
  wire sqTap;
  wire tbFall;
  wire ctrlWrite;
  wire statusWrite;
  wire maskWrite;
  wire [2:0] newRate;
  wire [1:0] newSqRate;
  wire rateMisuse;
  wire sqMisuse;
  wire slowCodeBad;

  assign timeBaseEnable = timeBaseControl[`TBDO_BIT_TB_EN];
  assign timeBaseRateSelect = timeBaseControl[`TBDO_BIT_TB_RATE_HI:`TBDO_BIT_TB_RATE_LO];
  assign squareOutEnable = timeBaseControl[`TBDO_BIT_SQ_EN];
  assign squareOutRateSelect = timeBaseControl[`TBDO_BIT_SQ_RATE_HI:`TBDO_BIT_SQ_RATE_LO];
  assign lowSpeedDividerSource = timeBaseControl[`TBDO_BIT_LS_SRC];

  // slow and sleep modes always run the chain from fs
  assign useLowSpeed = lowSpeedDividerSource | lowSpeedModes;

  // fs is asynchronous: two flops, then an edge detector on the second only
  always @(posedge clk)
  begin
    if (rst)
    begin
      fsSync1 <= 1'b0;
      fsSync2 <= 1'b0;
      fsPrev <= 1'b0;
    end
    else
    begin
      fsSync1 <= fsClockPin;
      fsSync2 <= fsSync1;
      fsPrev <= fsSync2;
    end
  end

  assign fsTick = fsSync2 & ~fsPrev;

  tbdo_divider u_divider (
    .clk(clk),
    .rst(rst),
    .lowSpeed(useLowSpeed),
    .fsTick(fsTick),
    .chain(chain)
  );

  // same tap positions serve both sources since fs enters above the low stages
  always @*
  begin
    case (timeBaseRateSelect)
      3'b000: tbTapIndex = `TBDO_TB_TAP0;
      3'b001: tbTapIndex = `TBDO_TB_TAP1;
      3'b010: tbTapIndex = `TBDO_TB_TAP2;
      3'b011: tbTapIndex = `TBDO_TB_TAP3;
      3'b100: tbTapIndex = `TBDO_TB_TAP4;
      3'b101: tbTapIndex = `TBDO_TB_TAP5;
      3'b110: tbTapIndex = `TBDO_TB_TAP6;
      3'b111: tbTapIndex = `TBDO_TB_TAP7;
      default: tbTapIndex = `TBDO_TB_TAP0;
    endcase
  end

  always @*
  begin
    case (squareOutRateSelect)
      2'b00: sqTapIndex = `TBDO_SQ_TAP0;
      2'b01: sqTapIndex = `TBDO_SQ_TAP1;
      2'b10: sqTapIndex = `TBDO_SQ_TAP2;
      2'b11: sqTapIndex = `TBDO_SQ_TAP3;
      default: sqTapIndex = `TBDO_SQ_TAP0;
    endcase
  end

  assign tbTap = chain[tbTapIndex];
  assign sqTap = chain[sqTapIndex];

  // previous tap tracked even while disabled, so enabling never restarts the period
  always @(posedge clk)
  begin
    if (rst)
      tbTapPrev <= 1'b0;
    else
      tbTapPrev <= tbTap;
  end

  assign tbFall = timeBaseEnable & tbTapPrev & ~tbTap;

  always @(posedge clk)
  begin
    if (rst)
      timeBaseInterrupt <= 1'b0;
    else
      timeBaseInterrupt <= tbFall;
  end

  // pin idles high; chain bit is a true 50% square wave
  always @(posedge clk)
  begin
    if (rst)
      buzzerSquareOut_n <= 1'b1;
    else
      buzzerSquareOut_n <= ~(squareOutEnable & sqTap);
  end

  assign ctrlWrite = regWrite & (regAddr == `TBDO_ADDR_CTRL);
  assign statusWrite = regWrite & (regAddr == `TBDO_ADDR_STATUS);
  assign maskWrite = regWrite & (regAddr == `TBDO_ADDR_MASK);
  assign newRate = regWriteData[`TBDO_BIT_TB_RATE_HI:`TBDO_BIT_TB_RATE_LO];
  assign newSqRate = regWriteData[`TBDO_BIT_SQ_RATE_HI:`TBDO_BIT_SQ_RATE_LO];

  // misuse is only flagged; the write still lands so software keeps control
  assign rateMisuse = ctrlWrite & timeBaseEnable & (newRate != timeBaseRateSelect);
  assign sqMisuse = ctrlWrite & squareOutEnable & (newSqRate != squareOutRateSelect);
  assign slowCodeBad = lowSpeedModes & timeBaseEnable &
    (timeBaseRateSelect > `TBDO_SLOW_MAX_CODE);

  always @(posedge clk)
  begin
    if (rst)
      timeBaseControl <= `TBDO_CTRL_RESET;
    else if (ctrlWrite)
      timeBaseControl <= regWriteData;
  end

  always @(posedge clk)
  begin
    if (rst)
      mask <= `TBDO_MASK_RESET;
    else if (maskWrite)
      mask <= regWriteData[`TBDO_ST_W-1:0];
  end

  // write-one clears, but a same-cycle event wins over the clear
  always @*
  begin
    next_status = status;
    if (statusWrite)
      next_status = status & ~regWriteData[`TBDO_ST_W-1:0];
    if (tbFall)
      next_status[`TBDO_ST_TICK] = 1'b1;
    if (rateMisuse)
      next_status[`TBDO_ST_RATE_MISUSE] = 1'b1;
    if (slowCodeBad)
      next_status[`TBDO_ST_SLOW_CODE] = 1'b1;
    if (sqMisuse)
      next_status[`TBDO_ST_SQ_MISUSE] = 1'b1;
  end

  always @(posedge clk)
  begin
    if (rst)
      status <= `TBDO_STATUS_RESET;
    else
      status <= next_status;
  end

  assign irq = |(status & mask);

  always @*
  begin
    next_readData = 8'h00;
    case (regAddr)
      `TBDO_ADDR_CTRL: next_readData = timeBaseControl;
      `TBDO_ADDR_STATUS: next_readData = {4'h0, status};
      `TBDO_ADDR_MASK: next_readData = {4'h0, mask};
      default: next_readData = 8'h00;
    endcase
  end

  // data valid only in the cycle after the read strobe
  always @(posedge clk)
  begin
    if (rst)
      regReadData <= 8'h00;
    else if (regRead)
      regReadData <= next_readData;
    else
      regReadData <= 8'h00;
  end

endmodule // tbdo_core

// file: verification/tbdo_core_assertions.sv
// port assertions for the time base and square output block
`timescale 1ns/1ps
`include "tbdo_defs.vh"
module tbdo_core_assertions (
  input wire clk,
  input wire rst,
  input wire [`TBDO_ADDR_W-1:0] regAddr,
  input wire [7:0] regWriteData,
  input wire regWrite,
  input wire regRead,
  input wire [7:0] regReadData,
  input wire lowSpeedModes,
  input wire timeBaseInterrupt,
  input wire irq,
  input wire buzzerSquareOut_n
);
  reg [7:0] ctrl;
  reg [3:0] mask;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // shadows of what software wrote, so reads and outputs can be judged
  always @(posedge clk)
  begin
    if (rst)
    begin
      ctrl <= 8'h00;
      mask <= 4'h0;
    end
    else if (regWrite && regAddr == `TBDO_ADDR_CTRL)
      ctrl <= regWriteData;
    else if (regWrite && regAddr == `TBDO_ADDR_MASK)
      mask <= regWriteData[3:0];
  end
  property p_pulse; timeBaseInterrupt |=> !timeBaseInterrupt; endproperty
  a_pulse: assert property (p_pulse) else $error("pulse too long");
  property p_ctrlRead; regRead && regAddr == `TBDO_ADDR_CTRL |=> regReadData == $past(ctrl); endproperty
  a_ctrlRead: assert property (p_ctrlRead) else $error("control read wrong");
  property p_unmapped; regRead && regAddr > `TBDO_ADDR_MASK |=> regReadData == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_sqOff; !ctrl[`TBDO_BIT_SQ_EN] |=> buzzerSquareOut_n; endproperty
  a_sqOff: assert property (p_sqOff) else $error("pin low while off");
  property p_tbOff; !ctrl[`TBDO_BIT_TB_EN] [*3] |=> !timeBaseInterrupt; endproperty
  a_tbOff: assert property (p_tbOff) else $error("tick while off");
  property p_irqMasked; mask == 4'h0 |-> !irq; endproperty
  a_irqMasked: assert property (p_irqMasked) else $error("irq while masked");
  property p_irqTick; timeBaseInterrupt && mask[0] |-> irq; endproperty
  a_irqTick: assert property (p_irqTick) else $error("irq missing");
  // fastest fast-clock tap is 512 cycles, so no two ticks within 8
  property p_hfSpacing; timeBaseInterrupt && !ctrl[4] && !lowSpeedModes |=> !timeBaseInterrupt [*8]; endproperty
  a_hfSpacing: assert property (p_hfSpacing) else $error("ticks too close");
endmodule // tbdo_core_assertions
bind tbdo_core tbdo_core_assertions u_chk (.*);

// file: verification/tbdo_buzzer.sv
// piezo buzzer model: counts pin edges and times the gap between them
`timescale 1ns/1ps
module tbdo_buzzer (
  input wire clk,
  input wire pinN,
  output int edgeCount,
  output int edgeGap
);
  reg last = 1'b1;
  int run;
  // pin idles high; each change of level closes one half period
  always @(posedge clk)
  begin
    last <= pinN;
    run <= (pinN != last) ? 1 : run + 1;
    if (pinN != last)
    begin
      edgeCount <= edgeCount + 1;
      edgeGap <= run;
    end
  end
endmodule // tbdo_buzzer

// file: verification/tb_top.sv
// testbench: register access, tick periods and square output periods
`timescale 1ns/1ps
`include "tbdo_defs.vh"
module tb_top;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [7:0] regAddr = 8'h00;
  reg [7:0] regWriteData = 8'h00;
  reg regWrite = 1'b0;
  reg regRead = 1'b0;
  reg lowSpeedModes = 1'b0;
  reg fsClockPin = 1'b0;
  wire [7:0] regReadData;
  wire timeBaseInterrupt;
  wire irq;
  wire buzzerSquareOut_n;
  int bad_count, samples_checked, seed, tbCount, tbGap, sinceTick, edgeCount, edgeGap, fsDiv, s, c;
  int hfExp[8] = '{23, 21, 16, 14, 13, 12, 11, 9};
  int lsExp[8] = '{15, 13, 8, 6, 5, 4, 3, 1};
  reg [7:0] d;
  tbdo_core u_tbdo_core (.*);
  tbdo_buzzer u_tbdo_buzzer (.clk(clk), .pinN(buzzerSquareOut_n), .edgeCount(edgeCount),
    .edgeGap(edgeGap));
  always #20 clk = ~clk;
  // fs at a tenth of clk keeps each level five cycles, above the sync minimum
  always @(posedge clk)
  begin
    fsDiv <= (fsDiv == 4) ? 0 : fsDiv + 1;
    if (fsDiv == 4)
      fsClockPin <= ~fsClockPin;
    sinceTick <= timeBaseInterrupt ? 1 : sinceTick + 1;
    if (timeBaseInterrupt)
    begin
      tbCount <= tbCount + 1;
      tbGap <= sinceTick;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
  begin
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  task wr(input [7:0] a, input [7:0] v);
  begin
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWriteData <= v;
    @(posedge clk);
    regWrite <= 1'b0;
  end
  endtask
  task rd(input [7:0] a, input [7:0] e);
  begin
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    #1 chk(regReadData, e);
  end
  endtask
  task end_of_test;
  begin
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask
  // the first event after enabling may be early, so callers skip it
  task waitEv(input bit onPin, input int n);
    int t, i;
  begin
    t = (onPin ? edgeCount : tbCount) + n;
    for (i = 0; i < 20000 && (onPin ? edgeCount : tbCount) < t; i++)
      @(posedge clk);
    if (i == 20000)
    begin
      bad_count++;
      end_of_test();
    end
  end
  endtask
  initial
  begin
    seed = 36300;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(`TBDO_ADDR_CTRL, 8'h00);
    rd(`TBDO_ADDR_STATUS, 8'h00);
    rd(8'h39, 8'h00);
    repeat (4)
    begin
      d = 8'($random(seed)) & 8'h77;
      wr(`TBDO_ADDR_CTRL, d);
      rd(`TBDO_ADDR_CTRL, d);
    end
    wr(`TBDO_ADDR_MASK, 8'h01);
    for (s = 0; s < 2; s++)
      for (c = 4; c < 8; c++)
      begin
        wr(`TBDO_ADDR_CTRL, 8'(s * 16 + c));
        wr(`TBDO_ADDR_CTRL, 8'(s * 16 + 8 + c));
        // first tick may be early; the second closes one full period within the wait bound
        waitEv(1'b0, 2);
        chk(tbGap, s ? 10 << lsExp[c] : 1 << hfExp[c]);
        wr(`TBDO_ADDR_CTRL, 8'(s * 16 + c));
      end
    rd(`TBDO_ADDR_STATUS, 8'h01);
    chk(irq, 1'b1);
    wr(`TBDO_ADDR_STATUS, 8'h01);
    rd(`TBDO_ADDR_STATUS, 8'h00);
    chk(irq, 1'b0);
    wr(`TBDO_ADDR_MASK, 8'h00);
    for (s = 0; s < 2; s++)
    begin
      c = $random(seed) & 3;
      lowSpeedModes <= s[0];
      wr(`TBDO_ADDR_CTRL, 8'(c * 32));
      wr(`TBDO_ADDR_CTRL, 8'(128 + c * 32));
      waitEv(1'b1, 3);
      chk(edgeGap, s ? 10 << (4 - c) : 1 << (12 - c));
      waitEv(1'b1, 1);
      chk(edgeGap, s ? 10 << (4 - c) : 1 << (12 - c));
      wr(`TBDO_ADDR_CTRL, 8'(c * 32));
      repeat (3) @(posedge clk);
      chk(buzzerSquareOut_n, 1'b1);
    end
    end_of_test();
  end
endmodule // tb_top
